/* pkg/lcs_pkg.sv */
// package: register map, reset values, timing constants and types of the led current bank
package lcs_pkg;

    localparam logic [6:0] ADDR_RAMP_DOWN  = 7'h11;
    localparam logic [6:0] ADDR_RAMP_UP    = 7'h12;
    localparam logic [6:0] ADDR_PORT_LOW   = 7'h13;
    localparam logic [6:0] ADDR_PORT_HIGH  = 7'h14;
    localparam logic [6:0] ADDR_GLOBAL     = 7'h15;

    localparam logic [7:0] RST_PORT_LOW    = 8'h00;
    localparam logic [1:0] RST_PORT_HIGH   = 2'h0;
    localparam logic [2:0] RST_GLOBAL_CODE = 3'h7;
    localparam logic [5:0] RST_RAMP_DOWN   = 6'h00;
    localparam logic [2:0] RST_RAMP_UP     = 3'h0;

    localparam int         FADE_LSB        = 0;
    localparam int         HOLD_LSB        = 3;
    localparam int         CODE_W          = 3;

    localparam logic [2:0] LEVEL_FULL      = 3'h7;
    localparam logic [2:0] LEVEL_OFF       = 3'h0;

    // shortest interval is 1/16 s of the pwm clock; each code step doubles it
    localparam int         PWM_CLOCK_HZ    = 32768;
    localparam int         BASE_DIVISOR    = 16;
    localparam int         BASE_TICKS      = PWM_CLOCK_HZ / BASE_DIVISOR;
    localparam int         STEP_SHIFT      = 3;
    localparam int         CNT_W           = 18;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } lcs_reg_req_t;

    typedef struct packed {
        logic holding;
        logic fading;
        logic ramping;
        logic shutdown;
    } lcs_status_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_HOLD  = 3'b001,
        ST_FADE  = 3'b010,
        ST_SHDN  = 3'b011,
        ST_RAMP  = 3'b100
    } lcs_state_t;

endpackage : lcs_pkg

/* rtl/lcs_current_regs.sv */
// led current select registers with automatic ramp-down and ramp-up sequencing
// Functional notes
// - ports 0-7 half/full select bits
// - ports 8-9 bits 1:0, upper bits zero
// - global code: full = (code+1) x 2.5 mA
// - global code resets to maximum, 20 mA
// - port current is global scaled by select
// - select changes apply immediately while active
// - ramp-down: hold full, fade, then shutdown
// - sequences run alone once started
// - fade-off code bits 2:0, zero is instant
// - hold-off code bits 5:3, bits 7:6 zero
// - ramp-up code bits 2:0, zero is instant
// - intervals counted in pwm clock ticks
`timescale 1ns/1ns
module lcs_current_regs #(
    parameter int P_BASE_TICKS = lcs_pkg::BASE_TICKS
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    input  wire lcs_pkg::lcs_reg_req_t i_req,
    input  wire logic                 i_pwm_tick,
    input  wire logic                 i_ramp_down_req,
    input  wire logic                 i_ramp_up_req,
    output logic [7:0]                o_rdata,
    output logic [9:0]                o_port_full,
    output logic [2:0]                o_global_code,
    output logic [2:0]                o_drive_code,
    output lcs_pkg::lcs_status_t      o_status
);

    // interval length of a nonzero code in pwm ticks
    function automatic logic [lcs_pkg::CNT_W-1:0] lcs_interval(input logic [2:0] code);
        logic [lcs_pkg::CNT_W-1:0] base;
        base = lcs_pkg::CNT_W'(P_BASE_TICKS);
        return base << (code - 3'h1);
    endfunction : lcs_interval

    // one of eight dac steps; never below one tick so short bases still advance
    function automatic logic [lcs_pkg::CNT_W-1:0] lcs_step(input logic [2:0] code);
        logic [lcs_pkg::CNT_W-1:0] s;
        s = lcs_interval(code) >> lcs_pkg::STEP_SHIFT;
        return (s == '0) ? lcs_pkg::CNT_W'(1) : s;
    endfunction : lcs_step

    // ---------------- register group ----------------
    logic [7:0] port_lo_q, port_lo_d;
    logic [1:0] port_hi_q, port_hi_d;
    logic [2:0] glob_q,    glob_d;
    logic [5:0] rdown_q,   rdown_d;
    logic [2:0] rup_q,     rup_d;
    logic [7:0] rdata_q,   rdata_d;

    always_comb begin
        port_lo_d = port_lo_q;
        port_hi_d = port_hi_q;
        glob_d    = glob_q;
        rdown_d   = rdown_q;
        rup_d     = rup_q;
        rdata_d   = rdata_q;
        if (i_req.wr) begin
            unique case (i_req.addr)
                lcs_pkg::ADDR_PORT_LOW:  port_lo_d = i_req.data;
                lcs_pkg::ADDR_PORT_HIGH: port_hi_d = i_req.data[1:0];
                lcs_pkg::ADDR_GLOBAL:    glob_d    = i_req.data[2:0];
                lcs_pkg::ADDR_RAMP_DOWN: rdown_d   = i_req.data[5:0];
                lcs_pkg::ADDR_RAMP_UP:   rup_d     = i_req.data[2:0];
                default: ;
            endcase
        end
        if (i_req.rd) begin
            unique case (i_req.addr)
                lcs_pkg::ADDR_PORT_LOW:  rdata_d = port_lo_q;
                lcs_pkg::ADDR_PORT_HIGH: rdata_d = {6'h00, port_hi_q};
                lcs_pkg::ADDR_GLOBAL:    rdata_d = {5'h00, glob_q};
                lcs_pkg::ADDR_RAMP_DOWN: rdata_d = {2'h0, rdown_q};
                lcs_pkg::ADDR_RAMP_UP:   rdata_d = {5'h00, rup_q};
                default:                 rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            port_lo_q <= lcs_pkg::RST_PORT_LOW;
            port_hi_q <= lcs_pkg::RST_PORT_HIGH;
            glob_q    <= lcs_pkg::RST_GLOBAL_CODE;
            rdown_q   <= lcs_pkg::RST_RAMP_DOWN;
            rup_q     <= lcs_pkg::RST_RAMP_UP;
            rdata_q   <= 8'h00;
        end else begin
            port_lo_q <= port_lo_d;
            port_hi_q <= port_hi_d;
            glob_q    <= glob_d;
            rdown_q   <= rdown_d;
            rup_q     <= rup_d;
            rdata_q   <= rdata_d;
        end
    end

    assign o_rdata       = rdata_q;
    assign o_port_full   = {port_hi_q, port_lo_q};
    assign o_global_code = glob_q;

    // ---------------- ramp sequencer group ----------------
    lcs_pkg::lcs_state_t       state_q, state_d;
    logic [lcs_pkg::CNT_W-1:0] cnt_q,   cnt_d;
    logic [2:0]                level_q, level_d;
    logic [2:0]                drive_q, drive_d;
    lcs_pkg::lcs_status_t      stat_q,  stat_d;
    logic [2:0]                fade_code;
    logic [2:0]                hold_code;

    assign fade_code = rdown_q[lcs_pkg::FADE_LSB +: lcs_pkg::CODE_W];
    assign hold_code = rdown_q[lcs_pkg::HOLD_LSB +: lcs_pkg::CODE_W];

    always_comb begin
        lcs_pkg::lcs_state_t       fs;
        logic [lcs_pkg::CNT_W-1:0] fc;
        logic [2:0]                fl;
        // entry into fade-off, shared by zero hold-off and the end of hold-off
        fs = (fade_code == 3'h0) ? lcs_pkg::ST_SHDN : lcs_pkg::ST_FADE;
        fc = lcs_step(fade_code) - lcs_pkg::CNT_W'(1);
        fl = (fade_code == 3'h0) ? lcs_pkg::LEVEL_OFF : lcs_pkg::LEVEL_FULL;
        state_d = state_q;
        cnt_d   = cnt_q;
        level_d = level_q;
        unique case (state_q)
            lcs_pkg::ST_RUN: begin
                if (i_ramp_down_req) begin
                    if (hold_code != 3'h0) begin
                        state_d = lcs_pkg::ST_HOLD;
                        cnt_d   = lcs_interval(hold_code) - lcs_pkg::CNT_W'(1);
                    end else begin
                        state_d = fs;
                        cnt_d   = fc;
                        level_d = fl;
                    end
                end
            end
            lcs_pkg::ST_HOLD: begin
                if (i_pwm_tick) begin
                    if (cnt_q == '0) begin
                        state_d = fs;
                        cnt_d   = fc;
                        level_d = fl;
                    end else begin
                        cnt_d = cnt_q - lcs_pkg::CNT_W'(1);
                    end
                end
            end
            lcs_pkg::ST_FADE: begin
                if (i_pwm_tick) begin
                    if (cnt_q != '0) begin
                        cnt_d = cnt_q - lcs_pkg::CNT_W'(1);
                    end else begin
                        level_d = level_q - 3'h1;
                        cnt_d   = lcs_step(fade_code) - lcs_pkg::CNT_W'(1);
                        if (level_q == 3'h1) begin
                            state_d = lcs_pkg::ST_SHDN;
                        end
                    end
                end
            end
            lcs_pkg::ST_SHDN: begin
                if (i_ramp_up_req) begin
                    if (rup_q == 3'h0) begin
                        state_d = lcs_pkg::ST_RUN;
                        level_d = lcs_pkg::LEVEL_FULL;
                    end else begin
                        state_d = lcs_pkg::ST_RAMP;
                        level_d = lcs_pkg::LEVEL_OFF;
                        cnt_d   = lcs_step(rup_q) - lcs_pkg::CNT_W'(1);
                    end
                end
            end
            lcs_pkg::ST_RAMP: begin
                if (i_pwm_tick) begin
                    if (cnt_q != '0) begin
                        cnt_d = cnt_q - lcs_pkg::CNT_W'(1);
                    end else begin
                        level_d = level_q + 3'h1;
                        cnt_d   = lcs_step(rup_q) - lcs_pkg::CNT_W'(1);
                        if (level_q == 3'h6) begin
                            state_d = lcs_pkg::ST_RUN;
                        end
                    end
                end
            end
            default: begin
                state_d = lcs_pkg::ST_RUN;
                level_d = lcs_pkg::LEVEL_FULL;
            end
        endcase
        // the fade dac only ever trims below the global ceiling
        drive_d = (level_d < glob_q) ? level_d : glob_q;
        stat_d.holding  = (state_d == lcs_pkg::ST_HOLD);
        stat_d.fading   = (state_d == lcs_pkg::ST_FADE);
        stat_d.ramping  = (state_d == lcs_pkg::ST_RAMP);
        stat_d.shutdown = (state_d == lcs_pkg::ST_SHDN);
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= lcs_pkg::ST_RUN;
            cnt_q   <= '0;
            level_q <= lcs_pkg::LEVEL_FULL;
            drive_q <= lcs_pkg::RST_GLOBAL_CODE;
            stat_q  <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            level_q <= level_d;
            drive_q <= drive_d;
            stat_q  <= stat_d;
        end
    end

    assign o_drive_code = drive_q;
    assign o_status     = stat_q;

    // ---------------- checks ----------------
    sequence fade_last_step;
        state_q == lcs_pkg::ST_FADE && i_pwm_tick && cnt_q == '0 && level_q == 3'h1;
    endsequence

    sequence run_write_low;
        state_q == lcs_pkg::ST_RUN && i_req.wr && i_req.addr == lcs_pkg::ADDR_PORT_LOW;
    endsequence

    low_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.wr && i_req.addr == lcs_pkg::ADDR_PORT_LOW |=> port_lo_q == $past(i_req.data))
        else $error("port select low not stored");
    high_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.rd && i_req.addr == lcs_pkg::ADDR_PORT_HIGH
        |=> o_rdata[7:2] == 6'h00 && o_rdata[1:0] == $past(port_hi_q))
        else $error("port select high readback wrong");
    glob_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.wr && i_req.addr == lcs_pkg::ADDR_GLOBAL |=> glob_q == $past(i_req.data[2:0]))
        else $error("global code not stored");
    drive_cap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ##1 o_drive_code <= $past(glob_q))
        else $error("drive code above global ceiling");
    // level is full whenever the sequencer idles in run, so drive must track the global code
    run_drive_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == lcs_pkg::ST_RUN && !i_ramp_down_req |=> o_drive_code == $past(glob_q))
        else $error("drive code not at global level in run");
    live_select_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        run_write_low |=> o_port_full[7:0] == $past(i_req.data))
        else $error("select change not applied at once");
    hold_full_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == lcs_pkg::ST_HOLD |-> level_q == lcs_pkg::LEVEL_FULL && o_status.holding)
        else $error("current reduced during hold-off");
    fade_end_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        fade_last_step |=> state_q == lcs_pkg::ST_SHDN ##0 o_status.shutdown ##0 level_q == 3'h0)
        else $error("fade did not end in shutdown");
    rdown_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.rd && i_req.addr == lcs_pkg::ADDR_RAMP_DOWN |=> o_rdata[7:6] == 2'h0)
        else $error("ramp-down upper bits not zero");
    instant_up_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == lcs_pkg::ST_SHDN && i_ramp_up_req && rup_q == 3'h0
        |=> state_q == lcs_pkg::ST_RUN && level_q == lcs_pkg::LEVEL_FULL)
        else $error("instant ramp-up failed");
    tick_count_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_pwm_tick && state_q != lcs_pkg::ST_RUN && state_q != lcs_pkg::ST_SHDN
        |=> $stable(cnt_q) && $stable(level_q))
        else $error("timer moved without pwm tick");

endmodule : lcs_current_regs

/* sim/lcs_host.sv */
// host model: register accesses, ramp requests and pwm clock ticks
`timescale 1ns/1ns
module lcs_host (
    input  wire logic             i_clk,
    output lcs_pkg::lcs_reg_req_t o_req,
    output logic                  o_pwm_tick,
    output logic                  o_down,
    output logic                  o_up
);
    int tick_cnt = 0;

    initial begin
        o_req = '0;
        o_down = 1'b0;
        o_up = 1'b0;
    end

    // one tick every fourth cycle: far above 32768 hz so intervals stay short
    always @(posedge i_clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        o_pwm_tick <= #1 (tick_cnt == 3);
    end

    // one access per cycle, held for the whole cycle
    task automatic access(input logic wr, input logic rd, input logic [6:0] a,
                          input logic [7:0] d);
        @(posedge i_clk);
        #1 o_req = {wr, rd, a, d};
    endtask : access

    // single-cycle request; any pending access is cleared while it is raised
    task automatic ramp(input logic dn);
        @(posedge i_clk);
        #1 o_down = dn;
        o_req = '0;
        o_up = !dn;
        @(posedge i_clk);
        #1 o_down = 1'b0;
        o_up = 1'b0;
    endtask : ramp
endmodule : lcs_host

/* sim/tb.sv */
// self-checking bench for the led current select bank
`timescale 1ns/1ns
module tb;
    localparam int         BASE = 16;
    logic                  clk;
    logic                  resetn;
    lcs_pkg::lcs_reg_req_t req;
    logic                  tick;
    logic                  down;
    logic                  up;
    logic [7:0]            rdata;
    logic [9:0]            port_full;
    logic [2:0]            gcode;
    logic [2:0]            dcode;
    lcs_pkg::lcs_status_t  status;
    logic [7:0]            exp_q[$];
    logic                  pend = 1'b0;
    logic [31:0]           v;
    int                    n;
    int                    fails = 0;
    int                    samples_checked = 0;

    lcs_host i_host (.i_clk(clk), .o_req(req), .o_pwm_tick(tick), .o_down(down), .o_up(up));

    lcs_current_regs #(.P_BASE_TICKS(BASE)) i_dut (
        .i_clk(clk), .i_resetn(resetn), .i_req(req), .i_pwm_tick(tick),
        .i_ramp_down_req(down), .i_ramp_up_req(up), .o_rdata(rdata),
        .o_port_full(port_full), .o_global_code(gcode), .o_drive_code(dcode),
        .o_status(status)
    );

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.access(1'b1, 1'b0, a, d);
    endtask : wr

    // expectation is queued before the read is issued
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.access(1'b0, 1'b1, a, 8'h00);
    endtask : rd

    // counts pwm ticks while one status bit stays high, bounded
    task automatic count_phase(input int b, output int cnt);
        int g;
        cnt = 0;
        g = 0;
        while (status[b] === 1'b1 && g < 3000) begin
            @(posedge clk);
            #2 g++;
            if (tick === 1'b1) cnt++;
        end
        if (g >= 3000) fails++;
    endtask : count_phase

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) pend <= req.rd;

    always @(negedge clk) begin
        if (pend === 1'b1 && exp_q.size() > 0) begin
            chk("rdata", rdata, exp_q.pop_front());
        end
    end

    initial begin
        #3000000;
        fails++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        v = $urandom(32'h48196f63);
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        chk("global_out", {5'h0, gcode}, 8'h07);
        chk("drive_out", {5'h0, dcode}, 8'h07);
        rd(lcs_pkg::ADDR_GLOBAL, 8'h07);
        rd(lcs_pkg::ADDR_PORT_LOW, 8'h00);
        rd(lcs_pkg::ADDR_PORT_HIGH, 8'h00);
        rd(lcs_pkg::ADDR_RAMP_DOWN, 8'h00);
        rd(lcs_pkg::ADDR_RAMP_UP, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = $urandom();
            wr(lcs_pkg::ADDR_PORT_LOW, v[7:0]);
            wr(lcs_pkg::ADDR_PORT_HIGH, v[15:8]);
            wr(lcs_pkg::ADDR_GLOBAL, v[23:16]);
            wr(lcs_pkg::ADDR_RAMP_DOWN, v[31:24]);
            wr(lcs_pkg::ADDR_RAMP_UP, v[7:0]);
            wr(7'h16, v[15:8]);
            rd(lcs_pkg::ADDR_PORT_LOW, v[7:0]);
            rd(lcs_pkg::ADDR_PORT_HIGH, {6'h0, v[9:8]});
            rd(lcs_pkg::ADDR_GLOBAL, {5'h0, v[18:16]});
            rd(lcs_pkg::ADDR_RAMP_DOWN, {2'h0, v[29:24]});
            rd(lcs_pkg::ADDR_RAMP_UP, {5'h0, v[2:0]});
            rd(7'h16, 8'h00);
            i_host.access(1'b0, 1'b0, 7'h00, 8'h00);
            chk("port_full_lo", port_full[7:0], v[7:0]);
            chk("port_full_hi", {6'h0, port_full[9:8]}, {6'h0, v[9:8]});
            chk("drive_run", {5'h0, dcode}, {5'h0, v[18:16]});
        end
        for (int c = 0; c < 8; c++) begin
            wr(lcs_pkg::ADDR_GLOBAL, 8'(c));
            repeat (3) i_host.access(1'b0, 1'b0, 7'h00, 8'h00);
            chk("global_code", {5'h0, gcode}, 8'(c));
            chk("drive_code", {5'h0, dcode}, 8'(c));
        end
        wr(lcs_pkg::ADDR_RAMP_DOWN, 8'h09);
        wr(lcs_pkg::ADDR_RAMP_UP, 8'h01);
        i_host.ramp(1'b1);
        chk("hold_status", 8'(status), 8'h08);
        wr(lcs_pkg::ADDR_PORT_LOW, 8'h3c);
        i_host.access(1'b0, 1'b0, 7'h00, 8'h00);
        chk("select_live", port_full[7:0], 8'h3c);
        count_phase(3, n);
        chk("fade_status", 8'(status), 8'h04);
        count_phase(2, n);
        chk("fade_ticks", 8'(n >= 13 && n <= 15), 8'h01);
        chk("shdn_status", 8'(status), 8'h01);
        #200 chk("shdn_drive", {5'h0, dcode}, 8'h00);
        i_host.ramp(1'b1);
        chk("shdn_ignore", 8'(status), 8'h01);
        i_host.ramp(1'b0);
        chk("up_status", 8'(status), 8'h02);
        count_phase(1, n);
        chk("up_ticks", 8'(n >= 13 && n <= 15), 8'h01);
        #200 chk("run_status", 8'(status), 8'h00);
        chk("run_drive", {5'h0, dcode}, 8'h07);
        v = $urandom();
        wr(lcs_pkg::ADDR_GLOBAL, v[7:0]);
        wr(lcs_pkg::ADDR_RAMP_DOWN, 8'h00);
        wr(lcs_pkg::ADDR_RAMP_UP, 8'h00);
        i_host.ramp(1'b1);
        chk("instant_shdn", 8'(status), 8'h01);
        chk("instant_drive", {5'h0, dcode}, 8'h00);
        i_host.ramp(1'b0);
        chk("instant_run", 8'(status), 8'h00);
        chk("instant_level", {5'h0, dcode}, {5'h0, v[2:0]});
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule : tb
